// ===== hdl/pfs_pkg.sv
// Constants for the port flow-control strap default loader.
// Assumes one 100 MHz clock and a single user of these definitions.
package pfs_pkg;

	// Latched soft-strap vector, one bit per strap.
	localparam int STRAP_W = 8;
	localparam int S_INT_FDX_PAUSE = 0;
	localparam int S_INT_MANUAL = 1;
	localparam int S_EXT_SPEED = 2;
	localparam int S_EXT_DPX_POL = 3;
	localparam int S_EXT_BACKPRESSURE = 4;
	localparam int S_EXT_FDX_PAUSE = 5;
	localparam int S_EXT_MANUAL = 6;
	localparam int S_HEARTBEAT_OFF = 7;
	// Strap defaults: fdx pause 1, manual 0, speed 1, bp 1, others 0.
	localparam logic [STRAP_W-1:0] STRAP_RST = 8'h35;

	// Register default bits produced by the decode.
	localparam int CFG_W = 18;
	localparam int C_INT_TX_PAUSE = 0;
	localparam int C_INT_RX_PAUSE = 1;
	localparam int C_INT_MANUAL_SEL = 2;
	localparam int C_INT_ADV_ASYM = 3;
	localparam int C_INT_ADV_SYM = 4;
	localparam int C_VP_LP_100FD = 5;
	localparam int C_VP_LP_100HD = 6;
	localparam int C_VP_LP_10FD = 7;
	localparam int C_VP_LP_10HD = 8;
	localparam int C_VP_LP_ASYM = 9;
	localparam int C_VP_LP_PAUSE = 10;
	localparam int C_EXT_BACKPRESSURE = 11;
	localparam int C_EXT_TX_PAUSE = 12;
	localparam int C_EXT_RX_PAUSE = 13;
	localparam int C_EXT_MANUAL_SEL = 14;
	localparam int C_VP_ADV_ASYM = 15;
	localparam int C_VP_ADV_SYM = 16;
	localparam int C_HEARTBEAT_OFF = 17;
	localparam logic [CFG_W-1:0] CFG_RST = 18'h00000;

	// External port operating modes (hard-strap encoding).
	localparam logic [1:0] MODE_MII_MAC = 2'h0;
	localparam logic [1:0] MODE_MII_PHY = 2'h1;
	localparam logic [1:0] MODE_RMII_PHY = 2'h2;

	// Cycles to wait after reset so the pin synchronisers hold real levels.
	localparam int SETTLE_CYC = 3;
	localparam int SETTLE_W = 2;

	typedef enum logic [1:0] {
		ST_SAMPLE = 2'h0,
		ST_LOAD = 2'h1,
		ST_APPLY = 2'h3,
		ST_RUN = 2'h2
	} pfs_state_e;

endpackage

// ===== hdl/pfs_sync.sv
// Two-flop synchroniser for a group of pin levels.
// Assumes the inputs are quasi-static straps or slow pin levels.
`timescale 1ns/1ps
module pfs_sync #(
	parameter int WIDTH = 1
) (
	// Clock and reset.
	input wire logic clk,
	input wire logic rstn,
	// Levels.
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] meta_q;

	// Refuse a width the flops cannot hold, at elaboration.
	if (WIDTH < 1) begin : g_bad_width
		$error("pfs_sync width must be at least one");
	end

	// The first stage feeds only the second stage.
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			meta_q <= '0;
			sync_out <= '0;
		end else begin
			meta_q <= async_in;
			sync_out <= meta_q;
		end
	end

endmodule

// ===== hdl/pfs_strap_loader.sv
// Soft-strap latch, loader override and register default decode for
// the internal-PHY port and the external MII port.
// Assumes strap pins are board levels, the loader and software sit on clk.
`timescale 1ns/1ps
module pfs_strap_loader (
	// Clock and reset.
	input wire logic clk,
	input wire logic rstn,
	// Strap pins and hard mode strap.
	input wire logic [pfs_pkg::STRAP_W-1:0] strap_pins,
	input wire logic [1:0] ext_mode,
	// Configuration loader.
	input wire logic ldr_busy,
	input wire logic ldr_wr,
	input wire logic [pfs_pkg::STRAP_W-1:0] ldr_mask,
	input wire logic [pfs_pkg::STRAP_W-1:0] ldr_data,
	// Register reset and software writes.
	input wire logic reg_rst,
	input wire logic sw_wr,
	input wire logic [pfs_pkg::CFG_W-1:0] sw_mask,
	input wire logic [pfs_pkg::CFG_W-1:0] sw_data,
	// External port link status.
	input wire logic ext_port_duplex_in,
	input wire logic vneg_fail,
	input wire logic vneg_speed_100,
	// Results.
	output logic defaults_ready,
	output logic [pfs_pkg::CFG_W-1:0] cfg_bits,
	output logic ext_full_duplex,
	output logic ext_speed_100
);

	pfs_pkg::pfs_state_e state_q;
	logic [pfs_pkg::SETTLE_W-1:0] settle_q;
	logic [pfs_pkg::STRAP_W-1:0] strap_q;
	logic [pfs_pkg::CFG_W-1:0] cfg_q;
	logic [pfs_pkg::STRAP_W-1:0] strap_s;
	logic dpx_s;
	logic dpx_full_q;
	logic speed_q;

	////////////////////////////////////////////////////////////////////////
	// Pin synchronisers.

	pfs_sync #(.WIDTH(pfs_pkg::STRAP_W + 1)) u_sync (
		.clk(clk),
		.rstn(rstn),
		.async_in({ext_port_duplex_in, strap_pins}),
		.sync_out({dpx_s, strap_s})
	);

	////////////////////////////////////////////////////////////////////////
	// Decode of the latched straps into register defaults.

	function automatic logic [pfs_pkg::CFG_W-1:0] decode(
		input logic [pfs_pkg::STRAP_W-1:0] s,
		input logic [1:0] mode
	);
		logic [pfs_pkg::CFG_W-1:0] c;
		logic mac;
		logic ext_man;
		logic spd;
		logic fdx;
		c = '0;
		mac = (mode == pfs_pkg::MODE_MII_MAC);
		ext_man = s[pfs_pkg::S_EXT_MANUAL] & ~mac;
		spd = s[pfs_pkg::S_EXT_SPEED];
		fdx = s[pfs_pkg::S_EXT_DPX_POL];
		c[pfs_pkg::C_INT_TX_PAUSE] = s[pfs_pkg::S_INT_FDX_PAUSE];
		c[pfs_pkg::C_INT_RX_PAUSE] = s[pfs_pkg::S_INT_FDX_PAUSE];
		c[pfs_pkg::C_INT_MANUAL_SEL] = s[pfs_pkg::S_INT_MANUAL];
		// A manually resolved port advertises no pause of its own.
		c[pfs_pkg::C_INT_ADV_ASYM] = ~s[pfs_pkg::S_INT_MANUAL]
			& s[pfs_pkg::S_INT_FDX_PAUSE];
		c[pfs_pkg::C_INT_ADV_SYM] = ~s[pfs_pkg::S_INT_MANUAL];
		c[pfs_pkg::C_VP_LP_100FD] = spd & fdx;
		c[pfs_pkg::C_VP_LP_100HD] = spd & ~fdx;
		c[pfs_pkg::C_VP_LP_10FD] = ~spd & fdx;
		c[pfs_pkg::C_VP_LP_10HD] = ~spd & ~fdx;
		c[pfs_pkg::C_VP_LP_ASYM] = s[pfs_pkg::S_EXT_FDX_PAUSE];
		c[pfs_pkg::C_VP_LP_PAUSE] = s[pfs_pkg::S_EXT_FDX_PAUSE];
		c[pfs_pkg::C_EXT_BACKPRESSURE] = s[pfs_pkg::S_EXT_BACKPRESSURE];
		c[pfs_pkg::C_EXT_TX_PAUSE] = s[pfs_pkg::S_EXT_FDX_PAUSE];
		c[pfs_pkg::C_EXT_RX_PAUSE] = s[pfs_pkg::S_EXT_FDX_PAUSE];
		c[pfs_pkg::C_EXT_MANUAL_SEL] = ext_man;
		// The virtual PHY does not exist in MAC mode.
		c[pfs_pkg::C_VP_ADV_ASYM] = ~ext_man & ~mac;
		c[pfs_pkg::C_VP_ADV_SYM] = ~ext_man & ~mac;
		c[pfs_pkg::C_HEARTBEAT_OFF] = s[pfs_pkg::S_HEARTBEAT_OFF]
			& (mode == pfs_pkg::MODE_MII_PHY);
		return c;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Sequencer: sample, loader window, apply, run.

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			state_q <= pfs_pkg::ST_SAMPLE;
		end else begin
			case (state_q)
				pfs_pkg::ST_SAMPLE: begin
					if (settle_q == pfs_pkg::SETTLE_W'(pfs_pkg::SETTLE_CYC)) begin
						state_q <= pfs_pkg::ST_LOAD;
					end
				end
				pfs_pkg::ST_LOAD: begin
					if (!ldr_busy) begin
						state_q <= pfs_pkg::ST_APPLY;
					end
				end
				pfs_pkg::ST_APPLY: begin
					state_q <= pfs_pkg::ST_RUN;
				end
				default: begin
					if (reg_rst) begin
						state_q <= pfs_pkg::ST_APPLY;
					end
				end
			endcase
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			settle_q <= '0;
		end else if (state_q == pfs_pkg::ST_SAMPLE) begin
			settle_q <= settle_q + pfs_pkg::SETTLE_W'(1);
		end
	end

	// Straps latch once; only the loader may change them afterwards.
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			strap_q <= pfs_pkg::STRAP_RST;
		end else if (state_q == pfs_pkg::ST_SAMPLE
				&& settle_q == pfs_pkg::SETTLE_W'(pfs_pkg::SETTLE_CYC)) begin
			strap_q <= strap_s;
		end else if (state_q == pfs_pkg::ST_LOAD && ldr_wr) begin
			strap_q <= (strap_q & ~ldr_mask) | (ldr_data & ldr_mask);
		end
	end

	// Software may overwrite any default once the block runs.
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			cfg_q <= pfs_pkg::CFG_RST;
		end else if (state_q == pfs_pkg::ST_APPLY) begin
			cfg_q <= decode(strap_q, ext_mode);
		end else if (state_q == pfs_pkg::ST_RUN && sw_wr && !reg_rst) begin
			cfg_q <= (cfg_q & ~sw_mask) | (sw_data & sw_mask);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// External port duplex and fallback speed.

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			dpx_full_q <= 1'b0;
		end else if (ext_mode == pfs_pkg::MODE_MII_MAC) begin
			dpx_full_q <= (dpx_s == strap_q[pfs_pkg::S_EXT_DPX_POL]);
		end else begin
			dpx_full_q <= cfg_q[pfs_pkg::C_VP_LP_100FD]
				| cfg_q[pfs_pkg::C_VP_LP_10FD];
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			speed_q <= 1'b0;
		end else if (vneg_fail) begin
			speed_q <= strap_q[pfs_pkg::S_EXT_SPEED];
		end else begin
			speed_q <= vneg_speed_100;
		end
	end

	assign defaults_ready = (state_q == pfs_pkg::ST_RUN);
	assign cfg_bits = cfg_q;
	assign ext_full_duplex = dpx_full_q;
	assign ext_speed_100 = speed_q;

	////////////////////////////////////////////////////////////////////////
	// Checks.

	chk_int_pause_load: assert property (
		@(posedge clk) disable iff (!rstn)
		state_q == pfs_pkg::ST_APPLY |=>
		cfg_q[pfs_pkg::C_INT_TX_PAUSE]
		== $past(strap_q[pfs_pkg::S_INT_FDX_PAUSE])
		&& cfg_q[pfs_pkg::C_INT_RX_PAUSE] == cfg_q[pfs_pkg::C_INT_TX_PAUSE])
		else $error("internal pause enables differ from strap");

	chk_int_manual_adv: assert property (
		@(posedge clk) disable iff (!rstn)
		state_q == pfs_pkg::ST_APPLY && strap_q[pfs_pkg::S_INT_MANUAL] |=>
		cfg_q[pfs_pkg::C_INT_MANUAL_SEL] && !cfg_q[pfs_pkg::C_INT_ADV_SYM]
		&& !cfg_q[pfs_pkg::C_INT_ADV_ASYM])
		else $error("internal manual strap not reflected");

	// The sampled reset keeps the release edge out: the flops were cleared there.
	chk_ext_speed_fallback: assert property (
		@(posedge clk) disable iff (!rstn)
		rstn && vneg_fail
		|=> ext_speed_100 == $past(strap_q[pfs_pkg::S_EXT_SPEED]))
		else $error("fallback speed not taken from strap");

	chk_duplex_polarity: assert property (
		@(posedge clk) disable iff (!rstn)
		rstn && ext_mode == pfs_pkg::MODE_MII_MAC
		##1 ext_mode == pfs_pkg::MODE_MII_MAC
		|-> ext_full_duplex == ($past(dpx_s)
		== $past(strap_q[pfs_pkg::S_EXT_DPX_POL])))
		else $error("duplex pin polarity wrong");

	chk_lp_ability_onehot: assert property (
		@(posedge clk) disable iff (!rstn)
		$past(state_q) == pfs_pkg::ST_APPLY |->
		$onehot(cfg_q[pfs_pkg::C_VP_LP_10HD:pfs_pkg::C_VP_LP_100FD])
		&& cfg_q[pfs_pkg::C_VP_LP_100FD]
		== ($past(strap_q[pfs_pkg::S_EXT_SPEED])
		&& $past(strap_q[pfs_pkg::S_EXT_DPX_POL])))
		else $error("partner ability bits wrong");

	chk_ext_pause_load: assert property (
		@(posedge clk) disable iff (!rstn)
		state_q == pfs_pkg::ST_APPLY |=>
		cfg_q[pfs_pkg::C_EXT_TX_PAUSE]
		== $past(strap_q[pfs_pkg::S_EXT_FDX_PAUSE])
		&& cfg_q[pfs_pkg::C_VP_LP_PAUSE] == cfg_q[pfs_pkg::C_EXT_RX_PAUSE]
		&& cfg_q[pfs_pkg::C_EXT_BACKPRESSURE]
		== $past(strap_q[pfs_pkg::S_EXT_BACKPRESSURE]))
		else $error("external pause defaults differ from strap");

	chk_mac_ignores_man: assert property (
		@(posedge clk) disable iff (!rstn)
		state_q == pfs_pkg::ST_APPLY && ext_mode == pfs_pkg::MODE_MII_MAC |=>
		!cfg_q[pfs_pkg::C_EXT_MANUAL_SEL] && !cfg_q[pfs_pkg::C_VP_ADV_SYM])
		else $error("manual strap used in MAC mode");

	chk_heartbeat_mode: assert property (
		@(posedge clk) disable iff (!rstn)
		state_q == pfs_pkg::ST_APPLY && ext_mode != pfs_pkg::MODE_MII_PHY |=>
		!cfg_q[pfs_pkg::C_HEARTBEAT_OFF])
		else $error("heartbeat-off set outside MII PHY mode");

	chk_override_window: assert property (
		@(posedge clk) disable iff (!rstn)
		state_q == pfs_pkg::ST_RUN |=> $stable(strap_q))
		else $error("straps changed after the loader window");

	chk_reset_reload: assert property (
		@(posedge clk) disable iff (!rstn)
		state_q == pfs_pkg::ST_RUN && reg_rst |=> state_q == pfs_pkg::ST_APPLY
		##1 cfg_q == decode($past(strap_q), $past(ext_mode)))
		else $error("register reset did not reload defaults");

	cov_loader_override: cover property (@(posedge clk) disable iff (!rstn)
		state_q == pfs_pkg::ST_LOAD && ldr_wr ##[1:20] defaults_ready);
	cov_reg_reset: cover property (@(posedge clk) disable iff (!rstn)
		defaults_ready && reg_rst ##2 defaults_ready);
	cov_fallback: cover property (@(posedge clk) disable iff (!rstn)
		vneg_fail ##1 ext_speed_100);
	cov_sw_write: cover property (@(posedge clk) disable iff (!rstn)
		defaults_ready && sw_wr ##1 cfg_bits != $past(cfg_bits));

endmodule

// ===== tb/pfs_board.sv
// Board model: strap pin levels and the configuration loader.
// Assumes clk and rstn from the bench, which also picks the override.
`timescale 1ns/1ps
module pfs_board (
	// Clock and reset.
	input wire logic clk,
	input wire logic rstn,
	// Settings from the bench.
	input wire logic [7:0] strap_val,
	input wire logic ovr_go,
	input wire logic [7:0] ovr_mask,
	input wire logic [7:0] ovr_data,
	input wire logic [3:0] busy_len,
	// Pins towards the block.
	output logic [7:0] strap_pins,
	output logic ldr_busy,
	output logic ldr_wr,
	output logic [7:0] ldr_mask,
	output logic [7:0] ldr_data
);
	int cyc;
	assign strap_pins = strap_val;
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			cyc <= 0;
		end else if (cyc < 63) begin
			cyc <= cyc + 1;
		end
	end
	// A long busy_len gives a slow loader; the write falls in the last busy cycle.
	assign ldr_busy = rstn && (cyc < 6 + int'(busy_len));
	assign ldr_wr = ovr_go && (cyc == 5 + int'(busy_len));
	// Outside the write the bus shows a pattern that must not be taken.
	assign ldr_mask = ldr_wr ? ovr_mask : ~ovr_mask;
	assign ldr_data = ldr_wr ? ovr_data : ~ovr_data;
endmodule

// ===== tb/pfs_strap_loader_tb.sv
// Self-checking bench for the strap default loader.
// Assumes the board model drives straps and loader; the bench the rest.
`timescale 1ns/1ps
module pfs_strap_loader_tb;
	localparam logic [17:0] INT_M = 18'h0001f;
	localparam logic [17:0] LP_M = 18'h007e0;
	localparam logic [17:0] EXT_M = 18'h1f800;
	localparam logic [17:0] HB_M = 18'h20000;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic [1:0] ext_mode = 2'h0;
	logic reg_rst = 1'b0;
	logic sw_wr = 1'b0;
	logic [17:0] sw_mask = 18'h00000;
	logic [17:0] sw_data = 18'h00000;
	logic dpx_pin = 1'b0;
	logic vneg_fail = 1'b0;
	logic vneg_spd = 1'b0;
	logic [7:0] strap_val = 8'h35;
	logic ovr_go = 1'b0;
	logic [7:0] ovr_mask = 8'h00;
	logic [7:0] ovr_data = 8'h00;
	logic [3:0] busy_len = 4'h0;
	logic [7:0] strap_pins, ldr_mask, ldr_data, s;
	logic ldr_busy, ldr_wr, ready, full_dpx, spd_100;
	logic [17:0] cfg_bits, exp_cfg;
	int fail_count = 0;
	int compares = 0;
	int cycles = 0;
	int i;

	always #5 clk = ~clk;

	pfs_board board (.clk(clk), .rstn(rstn), .strap_val(strap_val),
		.ovr_go(ovr_go), .ovr_mask(ovr_mask), .ovr_data(ovr_data),
		.busy_len(busy_len), .strap_pins(strap_pins), .ldr_busy(ldr_busy),
		.ldr_wr(ldr_wr), .ldr_mask(ldr_mask), .ldr_data(ldr_data));

	pfs_strap_loader DUT (.clk(clk), .rstn(rstn), .strap_pins(strap_pins),
		.ext_mode(ext_mode), .ldr_busy(ldr_busy), .ldr_wr(ldr_wr),
		.ldr_mask(ldr_mask), .ldr_data(ldr_data), .reg_rst(reg_rst),
		.sw_wr(sw_wr), .sw_mask(sw_mask), .sw_data(sw_data),
		.ext_port_duplex_in(dpx_pin), .vneg_fail(vneg_fail),
		.vneg_speed_100(vneg_spd), .defaults_ready(ready),
		.cfg_bits(cfg_bits), .ext_full_duplex(full_dpx),
		.ext_speed_100(spd_100));

	////////////////////////////////////////////////////////////////////////
	// Reference decode, built bit by bit from msb down to bit 0.
	function automatic logic [17:0] decode(logic [7:0] v, logic [1:0] m);
		logic mac;
		mac = (m == pfs_pkg::MODE_MII_MAC);
		return {v[7] & (m == pfs_pkg::MODE_MII_PHY), {2{~v[6] & ~mac}},
			v[6] & ~mac, {2{v[5]}}, v[4], {2{v[5]}},
			~v[2] & ~v[3], ~v[2] & v[3], v[2] & ~v[3], v[2] & v[3],
			~v[1], ~v[1] & v[0], v[1], {2{v[0]}}};
	endfunction

	task automatic check_cfg(logic [17:0] e, logic [17:0] g);
		compares++;
		if (g !== e) begin
			fail_count++;
			$display("unexpected cfg at %0t: exp %h got %h", $time, e, g);
		end
	endtask

	task automatic check_bit(logic e, logic g);
		compares++;
		if (g !== e) begin
			fail_count++;
			$display("unexpected bit at %0t: exp %h got %h", $time, e, g);
		end
	endtask

	// Defaults land a few cycles after release; a slow loader adds more.
	task automatic wait_ready();
		int k;
		for (k = 0; k < 40 && ready !== 1'b1; k++) begin
			@(posedge clk);
			#1;
		end
	endtask

	task automatic end_sim();
		$display("compares %0d, mismatches %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			fail_count++;
			end_sim();
		end
	end

	initial begin
		void'($urandom(32'h8688fa93));
		for (i = 0; i < 24; i++) begin
			// The first pass keeps the pin defaults and no override.
			@(posedge clk);
			rstn <= 1'b0;
			strap_val <= (i == 0) ? 8'h35 : 8'($urandom());
			ext_mode <= 2'(i % 3);
			ovr_go <= (i > 0) && 1'($urandom_range(1));
			ovr_mask <= 8'($urandom());
			ovr_data <= 8'($urandom());
			busy_len <= 4'($urandom());
			repeat (16) @(posedge clk);
			rstn <= 1'b1;
			@(posedge clk);
			#1;
			wait_ready();
			s = ovr_go ? (strap_val & ~ovr_mask) | (ovr_data & ovr_mask)
				: strap_val;
			exp_cfg = decode(s, ext_mode);
			check_cfg(exp_cfg & INT_M, cfg_bits & INT_M);
			check_cfg(exp_cfg & LP_M, cfg_bits & LP_M);
			check_cfg(exp_cfg & EXT_M, cfg_bits & EXT_M);
			check_cfg(exp_cfg & HB_M, cfg_bits & HB_M);
			@(posedge clk);
			sw_wr <= 1'b1;
			sw_mask <= 18'($urandom());
			sw_data <= 18'($urandom());
			@(posedge clk);
			sw_wr <= 1'b0;
			#1;
			exp_cfg = (exp_cfg & ~sw_mask) | (sw_data & sw_mask);
			check_cfg(exp_cfg, cfg_bits);
			@(posedge clk);
			reg_rst <= 1'b1;
			@(posedge clk);
			reg_rst <= 1'b0;
			#1;
			check_bit(1'b0, ready);
			repeat (2) @(posedge clk);
			#1;
			check_cfg(decode(s, ext_mode), cfg_bits);
			check_bit(1'b1, ready);
			@(posedge clk);
			vneg_fail <= 1'($urandom_range(1));
			vneg_spd <= 1'($urandom_range(1));
			dpx_pin <= 1'($urandom_range(1));
			repeat (5) @(posedge clk);
			#1;
			check_bit(vneg_fail ? s[2] : vneg_spd, spd_100);
			check_bit((ext_mode == pfs_pkg::MODE_MII_MAC) ?
				dpx_pin == s[3] : s[3], full_dpx);
			$display("test %0d done", i);
		end
		end_sim();
	end
endmodule
